// >>> hdl/two_tap_line_out.sv
// Two-tap line formatter feeding one link transmitter.
// Assumes a line memory on i_clk that holds the next pair
// ready on i_pair and advances it after each o_pair_take.
// The pixel clock arrives from outside and is sampled here.
`timescale 1ns/1ps
`include "two_tap_out_regs.svh"

module two_tap_line_out
	import two_tap_out_pkg::*;
#(
	parameter int CNT_W = `CNT_W
) (
	input  wire logic      i_clk,
	input  wire logic      i_srst,
	input  wire logic      i_ce,
	input  wire logic      i_pix_clk,
	input  wire logic      i_readout_done,
	input  wire tap_mode_e i_mode,
	input  wire line_cfg_s i_cfg,
	input  wire pix_pair_s i_pair,
	output cl_ports_s      o_cl,
	output logic           o_pair_take,
	output logic           o_busy
);

	// ----------------------------------------------------------------
	// Helper functions
	// ----------------------------------------------------------------

	// Pairs per line; odd counts round up, never below one pair
	function automatic logic [CNT_W-1:0] line_pairs(input line_cfg_s c);
		logic [CNT_W-1:0] n;
		logic [CNT_W:0]   s;
		n = `LINE_PIX_2K;
		case (c.model)
			MODEL_2K: n = `LINE_PIX_2K;
			MODEL_4K: n = `LINE_PIX_4K;
			MODEL_8K: n = `LINE_PIX_8K;
			default:  n = `LINE_PIX_2K;
		endcase
		if (c.hbin)
			n = n >> 1;
		if (c.area_of_interest_en)
			n = c.area_of_interest_width;
		s = {1'b0, n} + {{CNT_W{1'b0}}, 1'b1};
		line_pairs = s[CNT_W:1];
		if (line_pairs == '0)
			line_pairs = {{(CNT_W-1){1'b0}}, 1'b1};
	endfunction : line_pairs

	// Bit placement on the three ports, flags left clear
	function automatic cl_ports_s map_ports(input tap_mode_e m, input pix_pair_s p);
		logic [`PIX_W-1:0] f;
		logic [`PIX_W-1:0] s;
		f = p.first_pixel_stream;
		s = p.second_pixel_stream;
		map_ports = '0;
		case (m)
			MODE_12: begin
				map_ports.port_a = f[7:0];
				map_ports.port_b = {s[11:8], f[11:8]};
				map_ports.port_c = s[7:0];
			end
			MODE_10: begin
				map_ports.port_a = f[9:2];
				map_ports.port_b = {2'h0, s[11:10], 2'h0, f[11:10]};
				map_ports.port_c = s[9:2];
			end
			MODE_8: begin
				map_ports.port_a = f[11:4];
				map_ports.port_b = s[11:4];
				map_ports.port_c = 8'h00;
			end
			default: map_ports = '0;
		endcase
	endfunction : map_ports

	// ----------------------------------------------------------------
	// Pixel clock sampling
	// ----------------------------------------------------------------

	logic pclk_s1_r;
	logic pclk_s2_r;
	logic pclk_s3_r;
	logic pclk_rise;

	// Two flops before use; third flop for edge finding and the strobe
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pclk_s1_r <= 1'b0;
			pclk_s2_r <= 1'b0;
			pclk_s3_r <= 1'b0;
		end else if (i_ce) begin
			pclk_s1_r <= i_pix_clk;
			pclk_s2_r <= pclk_s1_r;
			pclk_s3_r <= pclk_s2_r;
		end
	end

	assign pclk_rise = i_ce & pclk_s2_r & ~pclk_s3_r;

	// ----------------------------------------------------------------
	// Line sequencer
	// ----------------------------------------------------------------

	line_state_e      state_r;
	logic             pend_r;
	logic [CNT_W-1:0] left_r;
	logic [CNT_W-1:0] pairs_r;
	tap_mode_e        mode_r;
	logic             start;
	logic             step;
	logic             last;

	assign start = pclk_rise & (state_r == ST_IDLE) & pend_r;
	assign step  = pclk_rise & (state_r == ST_SEND) & (left_r != '0);
	assign last  = pclk_rise & (state_r == ST_SEND) & (left_r == '0);

	// Readout-done is held until a line can start; a new one wins
	always_ff @(posedge i_clk) begin
		if (i_srst)
			pend_r <= 1'b0;
		else if (i_ce) begin
			if (i_readout_done)
				pend_r <= 1'b1;
			else if (start)
				pend_r <= 1'b0;
		end
	end

	// Idle/send state; each line ends with at least one idle cycle
	always_ff @(posedge i_clk) begin
		if (i_srst)
			state_r <= ST_IDLE;
		else if (i_ce) begin
			case (state_r)
				ST_IDLE: begin
					if (start)
						state_r <= ST_SEND;
				end
				ST_SEND: begin
					if (last)
						state_r <= ST_IDLE;
				end
				default: state_r <= ST_IDLE;
			endcase
		end
	end

	// Geometry and depth latched per line so mid-line edits wait
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			pairs_r <= '0;
			left_r  <= '0;
			mode_r  <= MODE_12;
		end else if (i_ce) begin
			if (start) begin
				pairs_r <= line_pairs(i_cfg);
				left_r  <= line_pairs(i_cfg) - {{(CNT_W-1){1'b0}}, 1'b1};
				mode_r  <= i_mode;
			end else if (step)
				left_r <= left_r - {{(CNT_W-1){1'b0}}, 1'b1};
		end
	end

	// ----------------------------------------------------------------
	// Transmitter word
	// ----------------------------------------------------------------

	cl_ports_s start_map;
	cl_ports_s step_map;

	// Port images: live mode for a new line, latched mode mid-line
	assign start_map = map_ports(i_mode, i_pair);
	assign step_map  = map_ports(mode_r, i_pair);

	// Data launched on the sampled rising edge; strobe lags one cycle
	always_ff @(posedge i_clk) begin
		if (i_srst)
			o_cl <= '0;
		else if (i_ce) begin
			o_cl.strobe <= pclk_s3_r;
			o_cl.fval   <= 1'b0;
			o_cl.spare  <= 1'b0;
			if (start) begin
				o_cl.port_a <= start_map.port_a;
				o_cl.port_b <= start_map.port_b;
				o_cl.port_c <= start_map.port_c;
				o_cl.lval   <= 1'b1;
				o_cl.dval   <= 1'b1;
			end else if (step) begin
				o_cl.port_a <= step_map.port_a;
				o_cl.port_b <= step_map.port_b;
				o_cl.port_c <= step_map.port_c;
			end else if (last) begin
				o_cl.lval <= 1'b0;
				o_cl.dval <= 1'b0;
			end
		end
	end

	// Take pulse tells the line memory to present the next pair
	always_ff @(posedge i_clk) begin
		if (i_srst) begin
			o_pair_take <= 1'b0;
			o_busy      <= 1'b0;
		end else if (i_ce) begin
			o_pair_take <= start | step;
			o_busy      <= pend_r | (state_r == ST_SEND);
		end
	end

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------

	logic [CNT_W:0] sent_r;

	// Pairs sent in the current line, checker use only
	always_ff @(posedge i_clk) begin
		if (i_srst)
			sent_r <= '0;
		else if (i_ce) begin
			if (start)
				sent_r <= {{CNT_W{1'b0}}, 1'b1};
			else if (step)
				sent_r <= sent_r + {{CNT_W{1'b0}}, 1'b1};
		end
	end

	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_srst);

	AST_IDLE_FLAGS_LOW: assert property (
		(state_r == ST_IDLE) && !$past(start) |-> !o_cl.lval && !o_cl.dval)
		else $error("flags high while idle");

	AST_FLAGS_TOGETHER: assert property (
		o_cl.lval == o_cl.dval)
		else $error("line and data valid differ");

	AST_START_AFTER_READOUT: assert property (
		$rose(o_cl.lval) |-> $past(pend_r) && $past(state_r) == ST_IDLE)
		else $error("line started without readout done");

	AST_FIRST_PAIR: assert property (
		start |=> o_cl.lval && o_pair_take && sent_r == 1
			&& o_cl.port_a == ($past(i_mode) == MODE_8 ? $past(i_pair.first_pixel_stream[11:4])
				: $past(i_mode) == MODE_10 ? $past(i_pair.first_pixel_stream[9:2])
				: $past(i_pair.first_pixel_stream[7:0]))
			&& o_cl.port_c == ($past(i_mode) == MODE_8 ? 8'h00
				: $past(i_mode) == MODE_10 ? $past(i_pair.second_pixel_stream[9:2])
				: $past(i_pair.second_pixel_stream[7:0])))
		else $error("first pair wrong");

	AST_ADVANCE: assert property (
		step |=> o_cl.lval && o_pair_take
			&& o_cl.port_b == (mode_r == MODE_8 ? $past(i_pair.second_pixel_stream[11:4])
				: mode_r == MODE_10 ? {2'h0, $past(i_pair.second_pixel_stream[11:10]), 2'h0,
					$past(i_pair.first_pixel_stream[11:10])}
				: {$past(i_pair.second_pixel_stream[11:8]), $past(i_pair.first_pixel_stream[11:8])}))
		else $error("pair not advanced");

	AST_LINE_END: assert property (
		last |=> !o_cl.lval ##0 !o_cl.dval ##0 !o_pair_take)
		else $error("line did not end");

	AST_LINE_LENGTH: assert property (
		$fell(o_cl.lval) |-> sent_r == {1'b0, pairs_r})
		else $error("wrong pair count in line");

	AST_UNUSED_LOW: assert property (
		!o_cl.fval && !o_cl.spare)
		else $error("unused bits driven high");

	AST_NARROW_ZERO: assert property (
		o_cl.lval && mode_r == MODE_10 |-> o_cl.port_b[7:6] == 2'h0
			&& o_cl.port_b[3:2] == 2'h0)
		else $error("10-bit unused bits high");

	AST_STROBE_FOLLOWS: assert property (
		pclk_rise && $stable(i_ce) ##1 i_ce |=> o_cl.strobe)
		else $error("strobe did not follow pixel clock");

	COV_LINE_START: cover property ($rose(o_cl.lval));
	COV_LINE_8BIT: cover property ($fell(o_cl.lval) && mode_r == MODE_8);
	COV_BACK_TO_BACK: cover property (last && pend_r);
	COV_AOI_LINE: cover property (start && i_cfg.area_of_interest_en);

endmodule : two_tap_line_out

// >>> hdl/two_tap_out_regs.svh
// Constants for the two-tap line output formatter.
// Assumes inclusion by the package and the formatter only.
`ifndef TWO_TAP_OUT_REGS_SVH
`define TWO_TAP_OUT_REGS_SVH

// Widths
`define PIX_W       12
`define PORT_W      8
`define CNT_W       14

// Full-resolution line lengths in pixels
`define LINE_PIX_2K 14'h0800
`define LINE_PIX_4K 14'h1000
`define LINE_PIX_8K 14'h2000

// Link clock synchroniser depth
`define SYNC_STAGES 2

`endif

// >>> hdl/two_tap_out_pkg.sv
// Types shared by the two-tap line output formatter.
// Assumes the constants header is on the include path.
`include "two_tap_out_regs.svh"

package two_tap_out_pkg;

	// Bit depth of the two-tap output
	typedef enum logic [1:0] {MODE_12, MODE_10, MODE_8} tap_mode_e;

	// Sensor width class
	typedef enum logic [1:0] {MODEL_2K, MODEL_4K, MODEL_8K} sensor_model_e;

	// Line sequencer states
	typedef enum logic {ST_IDLE, ST_SEND} line_state_e;

	// One pixel pair from the readout side
	typedef struct packed {
		logic [`PIX_W-1:0] first_pixel_stream;
		logic [`PIX_W-1:0] second_pixel_stream;
	} pix_pair_s;

	// Line geometry chosen by the camera setup
	typedef struct packed {
		sensor_model_e     model;
		logic              hbin;
		logic              area_of_interest_en;
		logic [`CNT_W-1:0] area_of_interest_width;
	} line_cfg_s;

	// Transmitter input word
	typedef struct packed {
		logic               lval;
		logic               dval;
		logic               fval;
		logic               spare;
		logic               strobe;
		logic [`PORT_W-1:0] port_a;
		logic [`PORT_W-1:0] port_b;
		logic [`PORT_W-1:0] port_c;
	} cl_ports_s;

endpackage : two_tap_out_pkg

// >>> sim/grabber_model.sv
// Frame grabber model on the far side of the two-tap link.
// Assumes strobe lags the data by one system clock, so the data
// is settled at each strobe rise.
`timescale 1ns/1ps

module grabber_model
	import two_tap_out_pkg::*;
(
	input  wire cl_ports_s i_cl
);
	// ----------------------------------------
	// Capture on strobe rise
	// ----------------------------------------
	logic [23:0] words [0:8191];
	int          n_words   = 0;
	int          n_strobes = 0;

	// Words outside a valid period are ignored, as a real grabber does
	always @(posedge i_cl.strobe) begin
		n_strobes <= n_strobes + 1;
		if (i_cl.lval && i_cl.dval) begin
			words[n_words] <= {i_cl.port_a, i_cl.port_b, i_cl.port_c};
			n_words        <= n_words + 1;
		end
	end
endmodule : grabber_model

// >>> sim/two_tap_line_scan_video_output_tb.sv
// Self-checking bench for the two-tap line formatter.
// Assumes the package is compiled first; pixel clock is free running.
`timescale 1ns/1ps

module two_tap_line_scan_video_output_tb;
	import two_tap_out_pkg::*;
	// ----------------------------------------
	// Stimulus and harness
	// ----------------------------------------
	logic      i_clk = 0;
	logic      i_srst = 1;
	logic      i_pix_clk = 0;
	logic      done = 0;
	logic      ce = 1;
	tap_mode_e mode = MODE_12;
	line_cfg_s cfg = '0;
	pix_pair_s i_pair;
	cl_ports_s o_cl;
	logic      o_pair_take;
	logic      o_busy;
	int        pidx = 0;
	int        split = 0;
	int        cyc = 0;
	int        errors = 0;
	int        samples_checked = 0;

	two_tap_line_out two_tap_line_out_inst (.i_clk(i_clk), .i_srst(i_srst), .i_ce(ce),
		.i_pix_clk(i_pix_clk), .i_readout_done(done), .i_mode(mode), .i_cfg(cfg),
		.i_pair(i_pair), .o_cl(o_cl), .o_pair_take(o_pair_take), .o_busy(o_busy));
	grabber_model grabber_model_inst (.i_cl(o_cl));

	initial forever #5 i_clk = ~i_clk;
	// Odd offset keeps the link clock unrelated in phase
	initial begin
		#3;
		forever #40 i_pix_clk = ~i_pix_clk;
	end

	function automatic logic [11:0] pix(input int n);
		pix = 12'(n * 12'h1A3);
	endfunction : pix

	// Line memory: next pair shows after each take
	always @* i_pair = '{pix(2 * pidx + 1), pix(2 * pidx + 2)};
	always @(negedge i_clk) begin
		if (o_pair_take === 1'b1 && ce)
			pidx <= pidx + 1;
		if (o_cl.lval !== o_cl.dval)
			split <= split + 1;
	end

	// Hang guard: longest line set is about 16k cycles, whole run about 33k
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			errors++;
			final_report();
		end
	end

	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	function automatic logic [23:0] exp_word(input tap_mode_e m, input logic [11:0] f, input logic [11:0] s);
		case (m)
			MODE_12: exp_word = {f[7:0], s[11:8], f[11:8], s[7:0]};
			MODE_10: exp_word = {f[9:2], 2'h0, s[11:10], 2'h0, f[11:10], s[9:2]};
			default: exp_word = {f[11:4], s[11:4], 8'h00};
		endcase
	endfunction : exp_word

	task automatic check_word(input logic [23:0] got, input logic [23:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: word %h expected %h", $time, got, exp);
		end
	endtask : check_word

	task automatic check_bit(input logic got, input logic exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: flag %b expected %b", $time, got, exp);
		end
	endtask : check_bit

	task automatic check_int(input int got, input int exp);
		samples_checked++;
		if (got != exp) begin
			errors++;
			$display("wrong value at %0t: count %0d expected %0d", $time, got, exp);
		end
	endtask : check_int

	task final_report;
		$display("checked %0d errors %0d", samples_checked, errors);
		if (errors == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : final_report

	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	// No readout yet: flags stay low but strobe keeps running
	task automatic idle_test;
		int s0;
		s0 = grabber_model_inst.n_strobes;
		repeat (40) begin
			@(negedge i_clk);
			check_bit(o_cl.lval | o_cl.dval, 1'h0);
		end
		check_bit(grabber_model_inst.n_strobes - s0 >= 4, 1'h1);
		$display("idle test done");
	endtask : idle_test

	// A second readout during the line must start the next line
	task automatic line_test(input tap_mode_e m, input line_cfg_s c, input int pairs, input int lines);
		int base;
		int w;
		base = grabber_model_inst.n_words;
		@(negedge i_clk);
		mode = m;
		cfg  = c;
		pidx = 0;
		done = 1;
		@(negedge i_clk);
		done = 0;
		if (lines == 2) begin
			repeat (20) @(negedge i_clk);
			done = 1;
			@(negedge i_clk);
			done = 0;
		end
		// Busy is registered from the pending flag, so it shows one cycle late
		@(negedge i_clk);
		check_bit(o_busy, 1'h1);
		w = 0;
		while (o_busy === 1'b1 && w < 40000) begin
			@(negedge i_clk);
			w++;
		end
		repeat (20) @(negedge i_clk);
		check_bit(o_busy, 1'h0);
		check_int(pidx, pairs * lines);
		check_int(grabber_model_inst.n_words - base, pairs * lines);
		for (int k = 0; k < pairs * lines; k++)
			check_word(grabber_model_inst.words[base + k], exp_word(m, pix(2 * k + 1), pix(2 * k + 2)));
		check_bit(o_cl.lval | o_cl.dval, 1'h0);
		check_bit(o_cl.fval | o_cl.spare, 1'h0);
		check_int(split, 0);
		$display("line test done");
	endtask : line_test

	// Enable low mid-line freezes every output; the line then completes
	task automatic ce_test;
		cl_ports_s held;
		int        base;
		base = grabber_model_inst.n_words;
		@(negedge i_clk);
		mode = MODE_12;
		cfg  = '{MODEL_2K, 1'h0, 1'h1, 14'h0010};
		pidx = 0;
		done = 1;
		@(negedge i_clk);
		done = 0;
		while (o_cl.lval !== 1'b1)
			@(negedge i_clk);
		@(negedge i_clk);
		ce   = 0;
		held = o_cl;
		repeat (30) begin
			@(negedge i_clk);
			check_bit({o_cl, o_pair_take, o_busy} === {held, 2'h1}, 1'h1);
		end
		ce = 1;
		repeat (200) @(negedge i_clk);
		check_bit(o_busy, 1'h0);
		check_int(pidx, 8);
		check_int(grabber_model_inst.n_words - base, 8);
		for (int k = 0; k < 8; k++)
			check_word(grabber_model_inst.words[base + k], exp_word(MODE_12, pix(2 * k + 1), pix(2 * k + 2)));
		$display("enable test done");
	endtask : ce_test

	initial begin
		repeat (3) @(negedge i_clk);
		i_srst = 0;
		idle_test();
		line_test(MODE_12, '{MODEL_2K, 1'h0, 1'h0, 14'h0000}, 1024, 1);
		line_test(MODE_8, '{MODEL_4K, 1'h1, 1'h0, 14'h0000}, 1024, 1);
		line_test(MODE_12, '{MODEL_8K, 1'h1, 1'h0, 14'h0000}, 2048, 1);
		line_test(MODE_10, '{MODEL_8K, 1'h1, 1'h1, 14'h000A}, 5, 2);
		ce_test();
		final_report();
	end
endmodule : two_tap_line_scan_video_output_tb
